// >>> rtl/return_rotate_pkg.sv
// Shared constants and types for the return and rotate execution block
package return_rotate_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int DATA_WIDTH = 8;   // Data path and literal width
	localparam int ADDR_WIDTH = 7;   // Register address within one bank
	localparam int PC_WIDTH   = 15;  // Program counter width

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [DATA_WIDTH-1:0] ACC_RESET   = 8'h00;
	localparam logic                  CARRY_RESET = 1'b0;
	localparam logic [PC_WIDTH-1:0]   PC_RESET    = 15'h0000;
	localparam logic [ADDR_WIDTH-1:0] ADDR_RESET  = 7'h00;

	// ************************************************************
	// Destination select and cycle counts
	// ************************************************************
	localparam logic DEST_ACC  = 1'b0;  // Result goes to the accumulator
	localparam logic DEST_FILE = 1'b1;  // Result goes back to the register
	localparam int   RETURN_CYCLES = 2; // Both return forms
	localparam int   ROTATE_CYCLES = 1; // Both rotate forms

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		op_none,
		op_return_literal,
		op_return_plain,
		op_rotate_left_carry,
		op_rotate_right_carry
	} op_type;

	typedef enum logic {
		st_idle,
		st_flush
	} state_type;

endpackage : return_rotate_pkg

// >>> rtl/carry_rotator.sv
// One-bit rotate through carry, left or right, purely combinational
`timescale 1ns/1ps
module carry_rotator #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] data_in,    // Operand
	input  wire logic             carry_in,   // Carry before the rotate
	input  wire logic             left,       // 1 rotates toward the MSB
	output logic      [WIDTH-1:0] data_out,   // Rotated operand
	output logic                  carry_out   // Carry after the rotate
);

	// Width of one bit cannot rotate meaningfully
	if (WIDTH < 2) begin : g_check
		$error("carry_rotator needs WIDTH of at least 2");
	end

	// ************************************************************
	// Rotate
	// ************************************************************
	// Left: MSB leaves into carry, carry enters bit 0; right is the mirror
	always_comb begin
		if (left) begin
			data_out  = {data_in[WIDTH-2:0], carry_in};
			carry_out = data_in[WIDTH-1];
		end else begin
			data_out  = {carry_in, data_in[WIDTH-1:1]};
			carry_out = data_in[0];
		end
	end

endmodule : carry_rotator

// >>> rtl/return_and_rotate_exec.sv
// Execution of return, return-with-literal and rotate-through-carry instructions
`timescale 1ns/1ps
module return_and_rotate_exec
	import return_rotate_pkg::*;
#(
	parameter int DWIDTH = return_rotate_pkg::DATA_WIDTH,  // Data width
	parameter int AWIDTH = return_rotate_pkg::ADDR_WIDTH,  // Bank address width
	parameter int PWIDTH = return_rotate_pkg::PC_WIDTH     // Program counter width
) (
	input  wire logic                            core_clk,        // Instruction clock
	input  wire logic                            rstn,            // Synchronous reset
	input  wire logic                            op_valid,        // Decoded instruction present
	input  wire return_rotate_pkg::op_type       op_code,         // Which instruction
	input  wire logic [DWIDTH-1:0]               op_literal,      // Immediate of literal return
	input  wire logic [AWIDTH-1:0]               op_file_addr,    // Register operand address
	input  wire logic                            op_dest,         // Destination select
	input  wire logic [DWIDTH-1:0]               file_rdata,      // Addressed register contents
	input  wire logic [PWIDTH-1:0]               stack_top_entry, // Return address on stack
	output logic      [DWIDTH-1:0]               acc,             // Accumulator
	output logic                                 carry,           // Carry flag
	output logic                                 pc_load,         // Load PC from pc_value
	output logic      [PWIDTH-1:0]               pc_value,        // New program counter
	output logic                                 stack_pop,       // Pop the hardware stack
	output logic                                 file_we,         // Write data memory
	output logic      [AWIDTH-1:0]               file_addr,       // Write address
	output logic      [DWIDTH-1:0]               file_wdata,      // Write data
	output logic                                 busy,            // Second cycle of a return
	output logic                                 done             // Instruction completed
);
	import return_rotate_pkg::*;

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// The state registers are sized from the package widths
	if (DWIDTH != DATA_WIDTH || AWIDTH != ADDR_WIDTH || PWIDTH != PC_WIDTH) begin : g_check
		$error("return_and_rotate_exec widths must match the package");
	end

	// ************************************************************
	// Decode
	// ************************************************************
	state_type         state;        // Idle or flushing a return
	logic              accept;       // Instruction taken this cycle
	logic              is_return;    // Either return form
	logic              is_rotate;    // Either rotate form
	logic              rot_left;     // Rotate direction
	logic [DWIDTH-1:0] rot_data;     // Rotated operand
	logic              rot_carry;    // Carry after rotate
	logic [1:0]        flush_count;  // Cycles left in a return

	// No new instruction is taken while a return is still flushing
	assign accept    = op_valid && (state == st_idle) && (op_code != op_none);
	assign is_return = (op_code == op_return_literal) || (op_code == op_return_plain);
	assign is_rotate = (op_code == op_rotate_left_carry) || (op_code == op_rotate_right_carry);
	assign rot_left  = (op_code == op_rotate_left_carry);

	// Shared rotator for both directions
	carry_rotator #(
		.WIDTH (DWIDTH)
	) u_rotator (
		.data_in   (file_rdata),
		.carry_in  (carry),
		.left      (rot_left),
		.data_out  (rot_data),
		.carry_out (rot_carry)
	);

	// ************************************************************
	// Sequencing
	// ************************************************************
	// A return spends its extra cycle in flush so the fetched word is dropped
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state       <= st_idle;
			flush_count <= 2'h0;
		end else begin
			case (state)
				st_idle: begin
					if (accept && is_return) begin
						state       <= st_flush;
						flush_count <= 2'(RETURN_CYCLES - 1);
					end
				end
				st_flush: begin
					if (flush_count == 2'h1) begin
						state       <= st_idle;
						flush_count <= 2'h0;
					end else begin
						flush_count <= flush_count - 2'h1;
					end
				end
				default: begin
					state       <= st_idle;
					flush_count <= 2'h0;
				end
			endcase
		end
	end

	// Busy mirrors the flush state; done marks the last cycle of any instruction
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			busy <= (accept && is_return) || (state == st_flush && flush_count != 2'h1);
			done <= (accept && is_rotate) || (state == st_flush && flush_count == 2'h1);
		end
	end

	// ************************************************************
	// Program counter and stack
	// ************************************************************
	// Both returns pop once and take the popped entry as the new PC
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pc_load   <= 1'b0;
			stack_pop <= 1'b0;
			pc_value  <= PC_RESET;
		end else begin
			pc_load   <= accept && is_return;
			stack_pop <= accept && is_return;
			if (accept && is_return) begin
				pc_value <= stack_top_entry;
			end
		end
	end

	// ************************************************************
	// Accumulator and carry
	// ************************************************************
	// Only rotates touch carry; returns leave every flag alone
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			acc   <= ACC_RESET;
			carry <= CARRY_RESET;
		end else if (accept) begin
			case (op_code)
				op_return_literal: begin
					acc <= op_literal;
				end
				op_rotate_left_carry, op_rotate_right_carry: begin
					carry <= rot_carry;
					if (op_dest == DEST_ACC) begin
						acc <= rot_data;
					end
				end
				default: begin
					acc <= acc;  // Plain return keeps the accumulator
				end
			endcase
		end
	end

	// ************************************************************
	// Data memory write-back
	// ************************************************************
	// Write strobe lasts one cycle; address stays confined to the bank
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			file_we    <= 1'b0;
			file_addr  <= ADDR_RESET;
			file_wdata <= ACC_RESET;
		end else begin
			file_we <= accept && is_rotate && (op_dest == DEST_FILE);
			if (accept && is_rotate) begin
				file_addr  <= op_file_addr;
				file_wdata <= rot_data;
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence ret_taken;
		accept && is_return;
	endsequence

	sequence ret_finish;
		busy && !done ##1 !busy && done;
	endsequence

	sequence rl_taken;
		accept && op_code == op_rotate_left_carry;
	endsequence

	sequence rr_taken;
		accept && op_code == op_rotate_right_carry;
	endsequence

	AST_RETURN_LITERAL_ACC: assert property (@(posedge core_clk) disable iff (!rstn)
		accept && op_code == op_return_literal |=> acc == $past(op_literal))
		else $error("literal return did not load the accumulator");

	AST_RET_PC: assert property (@(posedge core_clk) disable iff (!rstn)
		ret_taken |=> pc_load && stack_pop && pc_value == $past(stack_top_entry))
		else $error("return did not load PC from the stack top");

	AST_RET_TWO_CYCLES: assert property (@(posedge core_clk) disable iff (!rstn)
		ret_taken |=> ret_finish)
		else $error("return did not take two cycles");

	AST_RET_FLAGS: assert property (@(posedge core_clk) disable iff (!rstn)
		ret_taken |=> carry == $past(carry) ##1 !pc_load && !stack_pop)
		else $error("return changed carry or popped twice");

	AST_RL_RESULT: assert property (@(posedge core_clk) disable iff (!rstn)
		rl_taken and op_dest == DEST_ACC |=> acc == {$past(file_rdata[6:0]), $past(carry)}
			&& carry == $past(file_rdata[7]) && !file_we)
		else $error("left rotate into accumulator wrong");

	AST_RL_DEST: assert property (@(posedge core_clk) disable iff (!rstn)
		rl_taken and op_dest == DEST_FILE |=> file_we && acc == $past(acc)
			&& file_wdata == {$past(file_rdata[6:0]), $past(carry)})
		else $error("left rotate write-back wrong");

	AST_RR_RESULT: assert property (@(posedge core_clk) disable iff (!rstn)
		rr_taken and op_dest == DEST_ACC |=> acc == {$past(carry), $past(file_rdata[7:1])}
			&& carry == $past(file_rdata[0]))
		else $error("right rotate into accumulator wrong");

	AST_RR_DEST: assert property (@(posedge core_clk) disable iff (!rstn)
		rr_taken and op_dest == DEST_FILE |=> file_we && file_addr == $past(op_file_addr)
			&& file_wdata == {$past(carry), $past(file_rdata[7:1])} && acc == $past(acc))
		else $error("right rotate write-back wrong");

	AST_ROT_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!rstn)
		accept && is_rotate |=> done && !busy && !pc_load)
		else $error("rotate did not finish in one cycle");

	AST_WE_PULSE: assert property (@(posedge core_clk) disable iff (!rstn)
		file_we |-> $past(accept) && !busy)
		else $error("write strobe without a rotate");

endmodule : return_and_rotate_exec

// >>> dv/return_and_rotate_exec_tb_top.sv
// Self-checking random testbench for the return and rotate execution block
`timescale 1ns/1ps
module return_and_rotate_exec_tb_top;
	import return_rotate_pkg::*;
	// ************************************************************
	// Signals
	// ************************************************************
	logic                  core_clk = 1'b0;  // Instruction clock
	logic                  rstn     = 1'b0;  // Synchronous reset
	logic                  op_valid = 1'b0;  // Instruction present
	op_type                op_code  = op_none; // Instruction kind
	logic [DATA_WIDTH-1:0] op_literal = 8'h00; // Literal of a return
	logic [ADDR_WIDTH-1:0] op_file_addr = 7'h00; // Register operand
	logic                  op_dest  = 1'b0;  // Destination select
	logic [DATA_WIDTH-1:0] file_rdata = 8'h00; // Operand contents
	logic [PC_WIDTH-1:0]   stack_top_entry = 15'h0000; // Return address
	logic [DATA_WIDTH-1:0] acc;              // Accumulator
	logic                  carry;            // Carry flag
	logic                  pc_load;          // PC load pulse
	logic [PC_WIDTH-1:0]   pc_value;         // New PC
	logic                  stack_pop;        // Stack pop pulse
	logic                  file_we;          // Write pulse
	logic [ADDR_WIDTH-1:0] file_addr;        // Write address
	logic [DATA_WIDTH-1:0] file_wdata;       // Write data
	logic                  busy;             // Second return cycle
	logic                  done;             // Completion pulse
	int                    error_cnt = 0;    // Mismatches
	int                    compares  = 0;    // Comparisons made
	integer                seed      = 4460; // Fixed seed keeps runs repeatable
	logic [DATA_WIDTH-1:0] exp_acc;          // Expected accumulator
	logic                  exp_carry;        // Expected carry
	// ************************************************************
	// Clock and design
	// ************************************************************
	// 50 MHz clock
	always #10 core_clk = ~core_clk;
	return_and_rotate_exec dut (.core_clk(core_clk), .rstn(rstn), .op_valid(op_valid),
		.op_code(op_code), .op_literal(op_literal), .op_file_addr(op_file_addr),
		.op_dest(op_dest), .file_rdata(file_rdata), .stack_top_entry(stack_top_entry),
		.acc(acc), .carry(carry), .pc_load(pc_load), .pc_value(pc_value),
		.stack_pop(stack_pop), .file_we(file_we), .file_addr(file_addr),
		.file_wdata(file_wdata), .busy(busy), .done(done));
	// ************************************************************
	// Helpers
	// ************************************************************
	// Compare one value, widened to the widest port
	task check(input logic [PC_WIDTH-1:0] seen, input logic [PC_WIDTH-1:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Verdict and end of run
	task conclude;
		$display("Compares %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	// Inputs change a fixed 1 ns after the edge, away from sampling
	task tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	// Present one instruction on the decoder side
	task drive(input op_type op, input logic [7:0] k, input logic [7:0] rd,
		input logic [6:0] ad, input logic d, input logic [14:0] top);
		op_valid = (op != op_none);
		op_code = op;
		op_literal = k;
		file_rdata = rd;
		op_file_addr = ad;
		op_dest = d;
		stack_top_entry = top;
	endtask : drive
	// Rotate through carry: {new carry, result}
	function automatic logic [8:0] rot(input logic l, input logic [7:0] v, input logic c);
		return l ? {v, c} : {v[0], c, v[7:1]};
	endfunction : rot
	// One rotate, checked in the cycle after it is taken
	task do_rot(input logic l, input logic d, input logic [7:0] rd, input logic [6:0] ad);
		logic [8:0] r;
		r = rot(l, rd, exp_carry);
		drive(l ? op_rotate_left_carry : op_rotate_right_carry, 8'h00, rd, ad, d, 15'h0000);
		tick();
		exp_carry = r[8];
		if (d == DEST_ACC) begin
			exp_acc = r[7:0];
		end
		check(15'(done), 15'h0001);
		check(15'(carry), 15'(exp_carry));
		check(15'(acc), 15'(exp_acc));
		check(15'(file_we), 15'(d));
		check(15'(pc_load), 15'h0000);
		if (d == DEST_FILE) begin
			check(15'(file_wdata), 15'(r[7:0]));
			check(15'(file_addr), 15'(ad));
		end
	endtask : do_rot
	// A return, with a request held during the busy cycle that must be ignored
	task do_ret(input logic lit, input logic [7:0] k, input logic [14:0] top);
		drive(lit ? op_return_literal : op_return_plain, k, 8'h5a, 7'h11, 1'b1, top);
		tick();
		if (lit) begin
			exp_acc = k;
		end
		check(15'(pc_load), 15'h0001);
		check(15'(stack_pop), 15'h0001);
		check(pc_value, top);
		check(15'(acc), 15'(exp_acc));
		check(15'(busy), 15'h0001);
		check(15'(done), 15'h0000);
		drive(op_rotate_left_carry, 8'h00, ~exp_acc, 7'h22, DEST_ACC, ~top);
		tick();
		check(15'(done), 15'h0001);
		check(15'({busy, pc_load, stack_pop}), 15'h0000);
		check(15'(carry), 15'(exp_carry));
		drive(op_none, 8'h00, 8'h00, 7'h00, 1'b0, 15'h0000);
		tick();
		check(15'({done, file_we}), 15'h0000);
		check(15'(acc), 15'(exp_acc));
		check(pc_value, top);
	endtask : do_ret
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		check(15'({acc, carry}), 15'({ACC_RESET, CARRY_RESET}));
		check(15'({pc_load, stack_pop, busy, done, file_we}), 15'h0000);
		check(pc_value, PC_RESET);
		check(15'({file_addr, file_wdata}), 15'({ADDR_RESET, ACC_RESET}));
		exp_acc = ACC_RESET;
		exp_carry = CARRY_RESET;
		do_rot(1'b1, DEST_ACC, 8'he6, 7'h00);
		check(15'({acc, carry}), 15'({8'hcc, 1'b1}));
		do_rot(1'b0, DEST_FILE, 8'h01, 7'h7f);
		check(15'({file_wdata, carry}), 15'({8'h80, 1'b1}));
		do_ret(1'b1, 8'hff, 15'h7fff);
		do_ret(1'b0, 8'h3c, 15'h0001);
		// Back-to-back random rotates with returns scattered among them
		for (int i = 0; i < 300; i++) begin
			if (($random(seed) & 15) == 0) begin
				do_ret(1'($random(seed)), 8'($random(seed)), 15'($random(seed)));
			end else begin
				do_rot(1'($random(seed)), 1'($random(seed)), 8'($random(seed)),
					7'($random(seed)));
			end
		end
		drive(op_none, 8'h00, 8'h00, 7'h00, 1'b0, 15'h0000);
		tick();
		check(15'(done), 15'h0000);
		conclude();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end
endmodule : return_and_rotate_exec_tb_top
